/* File: hw/bfsm_pkg.sv */
`default_nettype none
package bfsm_pkg;
    // Link clock figures; the serial engine runs on its own link clock
    localparam int LINK_PERIOD_PS = 6000;   // Link clock period, ps
    localparam int SCLK_MAX_KHZ   = 36000;  // Fastest serial clock, kHz
    localparam int SCLK_MIN_KHZ   = 1400;   // Slowest serial clock, kHz
    localparam int HALF_PS_NUM    = 500000000; // Half period numerator, ps*kHz
    // Least half period rounds up, longest rounds down
    localparam int HALF_MIN_INT =
        (HALF_PS_NUM + SCLK_MAX_KHZ * LINK_PERIOD_PS - 1)
        / (SCLK_MAX_KHZ * LINK_PERIOD_PS);
    localparam int HALF_MAX_INT = HALF_PS_NUM / (SCLK_MIN_KHZ * LINK_PERIOD_PS);
    localparam logic [5:0] HALF_MIN = 6'(HALF_MIN_INT); // Link cycles
    localparam logic [5:0] HALF_MAX = 6'(HALF_MAX_INT); // Link cycles

    // Frame layout
    localparam int         FRAME_W   = 96;       // Longest frame, write and read bits
    localparam int         ADDR_W    = 24;       // Spans a 128 Mbit part
    localparam logic [6:0] OPC_BITS  = 7'h08;    // Opcode length
    localparam logic [6:0] ADDR_BITS = 7'h18;    // Address length
    localparam logic [2:0] MAX_BYTES = 3'h4;     // Data bytes each way per frame

    // Serial engine states
    typedef enum logic [0:0] {BFSM_IDLE, BFSM_RUN} bfsm_state_t;
endpackage
`default_nettype wire

/* File: hw/bfsm_top.sv */
// How it works
// - Programmable serial clock, about 1.41 to 27.8 MHz
// - 24-bit addresses cover 128 Mbit flash
// - Data shifts and select releases on falling edge
// - Return data sampled on falling edge
`timescale 1ns/10ps
`default_nettype none
module bfsm_top
    import bfsm_pkg::*;
(
    // Core clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    // Serial engine clock
    input  wire logic        LINK_CLK,
    // Command from the core
    input  wire logic        CMD_VALID,
    output logic             CMD_READY,
    input  wire logic [7:0]  CMD_OPCODE,
    input  wire logic        CMD_ADDR_EN,
    input  wire logic [23:0] CMD_ADDR,
    input  wire logic [2:0]  CMD_WBYTES,
    input  wire logic [31:0] CMD_WDATA,
    input  wire logic [2:0]  CMD_RBYTES,
    input  wire logic [5:0]  CMD_HALF,
    // Answer to the core
    output logic             RSP_VALID,
    output logic [31:0]      RSP_RDATA,
    // Flash pins
    output logic             FLASH_SCLK,
    output logic             FLASH_SELECT_N,
    output logic             FLASH_DOUT,
    input  wire logic        FLASH_DIN
);
    // Core side command holding registers
    logic        busy;        // Frame in flight
    logic        req_tgl;     // Toggles once per command
    logic [7:0]  c_opc;       // Held opcode
    logic        c_aen;       // Held address enable
    logic [23:0] c_addr;      // Held address
    logic [2:0]  c_wb;        // Held write byte count
    logic [31:0] c_wdata;     // Held write data
    logic [2:0]  c_rb;        // Held read byte count
    logic [5:0]  c_half;      // Held half period
    logic        ack_s1;      // Ack synchroniser, first stage
    logic        ack_s2;      // Ack synchroniser, second stage
    logic        ack_s3;      // Ack edge history

    // Link side state
    bfsm_state_t state;       // Engine state
    logic        ack_tgl;     // Toggles at frame end
    logic        req_s1;      // Request synchroniser, first stage
    logic        req_s2;      // Request synchroniser, second stage
    logic        req_s3;      // Request edge history
    logic        din_s1;      // Return data, first stage
    logic        din_s2;      // Return data, second stage
    logic [FRAME_W-1:0] shift; // Outgoing shifter
    logic [31:0] rx;          // Incoming shifter
    logic [6:0]  bit_cnt;     // Bits finished in frame
    logic [5:0]  cnt;         // Half period countdown
    logic        sclk;        // Serial clock level
    logic        sel_n;       // Select level

    // Command decode, fields on held registers, take on live CMD_VALID
    wire logic        take    = CMD_VALID & ~busy;
    wire logic        ack_evt = ack_s2 ^ ack_s3;
    wire logic        start   = req_s2 ^ req_s3;
    wire logic [2:0]  wb_c    = (c_wb > MAX_BYTES) ? MAX_BYTES : c_wb;
    wire logic [2:0]  rb_c    = (c_rb > MAX_BYTES) ? MAX_BYTES : c_rb;
    // Out of range rates are pulled into the legal band
    wire logic [5:0]  half_c  = (c_half < HALF_MIN) ? HALF_MIN :
                                (c_half > HALF_MAX) ? HALF_MAX : c_half;
    wire logic [5:0]  half_m1 = half_c - 6'h01;
    wire logic [6:0]  out_bits = OPC_BITS + (c_aen ? ADDR_BITS : 7'h00)
                               + {1'b0, wb_c, 3'h0};
    wire logic [6:0]  all_bits = out_bits + {1'b0, rb_c, 3'h0};
    wire logic [6:0]  last_idx = all_bits - 7'h01;
    // Opcode first, then full 24-bit address when enabled, then data, MSB first
    wire logic [FRAME_W-1:0] tx_aen = {c_opc, c_addr, c_wdata, 32'h0};
    wire logic [FRAME_W-1:0] tx_raw = {c_opc, c_wdata, 56'h0};
    wire logic [FRAME_W-1:0] tx_word = c_aen ? tx_aen : tx_raw;
    wire logic        tick    = (cnt == 6'h00);
    wire logic        in_read = (bit_cnt >= out_bits);
    wire logic        last    = (bit_cnt == last_idx);

    assign CMD_READY      = ~busy;
    assign FLASH_SCLK     = sclk;
    assign FLASH_SELECT_N = sel_n;
    assign FLASH_DOUT     = shift[FRAME_W-1];

    // Command capture and answer, core domain
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            busy      <= 1'b0;
            req_tgl   <= 1'b0;
            c_opc     <= 8'h00;
            c_aen     <= 1'b0;
            c_addr    <= 24'h000000;
            c_wb      <= 3'h0;
            c_wdata   <= 32'h00000000;
            c_rb      <= 3'h0;
            c_half    <= 6'h00;
            ack_s1    <= 1'b0;
            ack_s2    <= 1'b0;
            ack_s3    <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= 32'h00000000;
        end else begin
            ack_s1    <= ack_tgl;
            ack_s2    <= ack_s1;
            ack_s3    <= ack_s2;
            RSP_VALID <= ack_evt;
            // Fields stay frozen until the engine hands back
            if (take) begin
                busy    <= 1'b1;
                req_tgl <= ~req_tgl;
                c_opc   <= CMD_OPCODE;
                c_aen   <= CMD_ADDR_EN;
                c_addr  <= CMD_ADDR;
                c_wb    <= CMD_WBYTES;
                c_wdata <= CMD_WDATA;
                c_rb    <= CMD_RBYTES;
                c_half  <= CMD_HALF;
            end else if (ack_evt) begin
                busy      <= 1'b0;
                RSP_RDATA <= rx;  // Stable: engine idles after the toggle
            end
        end
    end

    // Synchronisers, link domain
    always_ff @(posedge LINK_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            din_s1 <= FLASH_DIN;
            din_s2 <= din_s1;
        end
    end

    // Serial engine; clock idles low, the flash captures on the rise
    always_ff @(posedge LINK_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state   <= BFSM_IDLE;
            ack_tgl <= 1'b0;
            shift   <= '0;
            rx      <= 32'h00000000;
            bit_cnt <= 7'h00;
            cnt     <= 6'h00;
            sclk    <= 1'b0;
            sel_n   <= 1'b1;
        end else begin
            unique case (state)
                BFSM_IDLE: begin
                    // Select drops a full half period before the first rise
                    if (start) begin
                        state   <= BFSM_RUN;
                        sel_n   <= 1'b0;
                        shift   <= tx_word;
                        rx      <= 32'h00000000;
                        bit_cnt <= 7'h00;
                        cnt     <= half_m1;
                    end
                end
                BFSM_RUN: begin
                    if (!tick) begin
                        cnt <= cnt - 6'h01;
                    end else if (!sclk) begin
                        cnt  <= half_m1;
                        sclk <= 1'b1;
                    end else begin
                        cnt  <= half_m1;
                        sclk <= 1'b0;
                        // Falling edge capture gives slow parts a full period
                        if (in_read) begin
                            rx <= {rx[30:0], din_s2};
                        end
                        if (last) begin
                            sel_n   <= 1'b1;
                            ack_tgl <= ~ack_tgl;
                            state   <= BFSM_IDLE;
                        end else begin
                            shift   <= {shift[FRAME_W-2:0], 1'b0};
                            bit_cnt <= bit_cnt + 7'h01;
                        end
                    end
                end
            endcase
        end
    end

    // Checks on the serial pins and the shifters
    AST_SCLK_HIGH_WIDTH: assert property (@(posedge LINK_CLK)
        disable iff (SYS_RST) $rose(sclk) |-> sclk [*3])
        else $error("Serial clock high too short");
    AST_SCLK_LOW_WIDTH: assert property (@(posedge LINK_CLK)
        disable iff (SYS_RST) $fell(sclk) |-> !sclk [*3])
        else $error("Serial clock low too short");
    AST_DOUT_ON_FALL: assert property (@(posedge LINK_CLK)
        disable iff (SYS_RST)
        $changed(FLASH_DOUT) |-> $fell(sclk) || $fell(sel_n))
        else $error("Data changed off a falling edge");
    AST_SEL_RISE_ON_FALL: assert property (@(posedge LINK_CLK)
        disable iff (SYS_RST) $rose(sel_n) |-> $fell(sclk))
        else $error("Select released off a falling edge");
    AST_RX_ON_FALL: assert property (@(posedge LINK_CLK)
        disable iff (SYS_RST)
        $changed(rx) && !$fell(sel_n) |-> $fell(sclk))
        else $error("Return data sampled off a falling edge");
    AST_SEL_LEADS_CLK: assert property (@(posedge LINK_CLK)
        disable iff (SYS_RST) $fell(sel_n) |-> !sclk [*3])
        else $error("Clock rose too soon after select");
    AST_CLK_INSIDE_SEL: assert property (@(posedge LINK_CLK)
        disable iff (SYS_RST) sclk |-> !sel_n)
        else $error("Clock high outside select");
    AST_ADDR_FULL: assert property (@(posedge LINK_CLK)
        disable iff (SYS_RST)
        // Address sits right below the opcode byte in the shifter
        start && c_aen |-> ##1 shift[FRAME_W-9 -: ADDR_W] == c_addr)
        else $error("Address not loaded in full");

    // Main scenarios
    COV_READ: cover property (@(posedge LINK_CLK)
        disable iff (SYS_RST) $rose(sel_n) && rb_c != 3'h0);
    COV_WRITE_ADDR: cover property (@(posedge LINK_CLK)
        disable iff (SYS_RST) $rose(sel_n) && c_aen && wb_c != 3'h0);
    COV_ANSWER: cover property (@(posedge CORE_CLK)
        disable iff (SYS_RST) RSP_VALID ##[1:20] take);
endmodule
`default_nettype wire

/* File: bench/bfsm_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Behavioural serial flash; answers with a fixed byte pattern
module bfsm_flash_model (
    // Flash pins
    input  wire logic        sclk,
    input  wire logic        select_n,
    input  wire logic        dout,
    output logic             din,
    // Observed frame
    output logic [63:0]      rx,
    output logic [7:0]       rises,
    output logic [7:0]       bad,
    output logic [15:0]      hi_ns
);
    realtime t_rise; // Time of last rise
    logic    held;   // Data seen just after last fall
    // Pattern bit for frame position p
    function automatic logic pat(input logic [7:0] p);
        logic [7:0] b;
        b = {3'h0, p[7:3]} ^ 8'h5a;
        return b[3'h7 - p[2:0]];
    endfunction
    // Quiet start
    initial begin
        {din, rx, rises, bad, hi_ns} = '0;
    end
    // New frame: clear count, drive first bit
    always @(negedge select_n) begin
        rises = 8'h00;
        din = pat(8'h00);
        #1 held = dout;
    end
    // Capture on rise; data must not move between the last fall and the rise
    always @(posedge sclk) begin
        t_rise = $realtime;
        if (select_n || dout !== held) bad = bad + 8'h01;
        rx = {rx[62:0], dout};
        rises = rises + 8'h01;
    end
    // Shift out next bit on fall
    always @(negedge sclk) begin
        // Rounded, since the real time difference may fall a hair short
        hi_ns = 16'($rtoi($realtime - t_rise + 0.5));
        if (!select_n) din = pat(rises);
        #1 held = dout;
    end
    // Released line shows the inverse, never a stale value
    always @(posedge select_n) din = ~din;
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    import bfsm_pkg::*;
    logic        core_clk, link_clk, sys_rst, valid, ready, aen; // Control
    logic [7:0]  opc;         // Command fields
    logic [23:0] addr;
    logic [2:0]  wb, rb;
    logic [31:0] wd, rdata;
    logic [5:0]  half;
    logic        rsp, sclk, sel_n, dout, din; // Answer and pins
    logic [63:0] rx;          // Flash view
    logic [7:0]  rises, bad;
    logic [15:0] hi_ns;
    int          miscompares = 0;
    int          cmp_count = 0;
    bfsm_top dut_u (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
        .LINK_CLK(link_clk), .CMD_VALID(valid), .CMD_READY(ready),
        .CMD_OPCODE(opc), .CMD_ADDR_EN(aen), .CMD_ADDR(addr),
        .CMD_WBYTES(wb), .CMD_WDATA(wd), .CMD_RBYTES(rb), .CMD_HALF(half),
        .RSP_VALID(rsp), .RSP_RDATA(rdata), .FLASH_SCLK(sclk),
        .FLASH_SELECT_N(sel_n), .FLASH_DOUT(dout), .FLASH_DIN(din));
    bfsm_flash_model flash_u (.sclk(sclk), .select_n(sel_n), .dout(dout),
        .din(din), .rx(rx), .rises(rises), .bad(bad), .hi_ns(hi_ns));
    // Core clock, 8 ns
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Link clock, 6 ns, offset phase
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    // Verdict and end of run
    task automatic complete_run();
        $display("Counts: %0d compared, %0d mismatched", cmp_count,
            miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One command, waits a bounded time for its answer
    task automatic run_cmd(input logic [7:0] o, input logic e,
        input logic [23:0] a, input logic [2:0] w, input logic [31:0] d,
        input logic [2:0] r, input logic [5:0] h);
        int n;
        @(posedge core_clk);
        #1;
        {opc, aen, addr, wb, wd, rb, half} = {o, e, a, w, d, r, h};
        valid = 1'b1;
        @(posedge core_clk);
        #1;
        valid = 1'b0;
        `CHK(ready, 1'b0)
        for (n = 0; n < 20000 && rsp !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        if (n == 20000) begin
            miscompares++;
            complete_run();
        end else begin
            // Ready is back in the answer cycle; the answer lasts one cycle
            `CHK(ready, 1'b1)
            @(posedge core_clk);
            #1;
            `CHK(rsp, 1'b0)
        end
    endtask
    // Read with address at fastest clock (half clamps up to 3)
    task automatic t_read();
        run_cmd(8'h03, 1'b1, 24'habcd12, 3'h0, 32'h0, 3'h4, 6'h01);
        `CHK(rx[63:32], 32'h03abcd12)
        `CHK(rdata, 32'h5e5f5c5d)
        `CHK(rises, 8'h40)
        `CHK(hi_ns, 16'h0012)
        `CHK(bad, 8'h00)
        $display("Test read done");
    endtask
    // Write, byte count over 4 and slowest clock (half clamps to 59)
    task automatic t_write();
        run_cmd(8'h02, 1'b1, 24'h000100, 3'h7, 32'h11223344, 3'h0, 6'h3f);
        `CHK(rx, 64'h0200010011223344)
        `CHK(rdata, 32'h00000000)
        `CHK(rises, 8'h40)
        `CHK(hi_ns, 16'h0162)
        `CHK(bad, 8'h00)
        $display("Test write done");
    endtask
    // Opcode only, three read bytes, issued straight after the last
    task automatic t_ident();
        run_cmd(8'h9f, 1'b0, 24'hffffff, 3'h0, 32'hffffffff, 3'h3, 6'h0a);
        `CHK(rx[31:24], 8'h9f)
        `CHK(rdata, 32'h005b5859)
        `CHK(rises, 8'h20)
        `CHK(hi_ns, 16'h003c)
        `CHK(bad, 8'h00)
        $display("Test ident done");
    endtask
    // Main sequence
    initial begin
        {sys_rst, valid, opc, aen, addr, wb, wd, rb, half} = '0;
        sys_rst = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        `CHK(sel_n, 1'b1)
        `CHK(sclk, 1'b0)
        `CHK(ready, 1'b1)
        `CHK(rsp, 1'b0)
        `CHK(rdata, 32'h00000000)
        t_read();
        t_ident();
        t_write();
        complete_run();
    end
endmodule
`default_nettype wire
